// ===== hw/fild_regs.vh
// constants for the integer part and base-ten logarithm decoder
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
// Overview of operation
// - first word is 1111, coprocessor id, 000, then mode and register.
// - select bit 0 means register to register, 1 means memory operand.
// - register form takes the source specifier as source register number.
// - memory form takes the source specifier as the operand format code.
// - address modes 010 to 110 use the register field as address register.
// - data register direct only for byte, word, long, single; address direct illegal.
// - mode 111 register picks absolute, immediate or pc relative forms.
// - operation 0000001 is integer part, 0000011 is truncating integer part.
// - truncating integer part rounds toward zero whatever mode is selected.
// - integer parts keep signed zero and signed infinity unchanged.
// - integer parts clear branch, operand, overflow, underflow, divide bits; quotient kept.
// - decimal input inexact is cleared unless the format is packed.
// - condition codes and accrued byte update after every operation.
// - base-ten logarithm converts, computes log base ten, writes destination.
// - logarithm of negative value gives nan with operand error, else cleared.
// - logarithm of zero gives minus infinity and divide by zero; plus infinity passes.
// - ordinary integer part rounds with the mode from the control register.
// - equal source and destination registers read and write that one register.
// - operation 0010101 is the base-ten logarithm.
`ifndef FILD_REGS_VH
`define FILD_REGS_VH
// register byte offsets
`define FILD_ADDR_CTRL   4'h0
`define FILD_ADDR_STAT   4'h4
`define FILD_ADDR_DEC    4'h8
// control register reset and field
`define FILD_CTRL_RST    8'h00
`define FILD_RMODE_HI    5
`define FILD_RMODE_LO    4
// rounding mode codes
`define FILD_RM_ZERO     2'h1
// instruction field values
`define FILD_W0_TOP      4'hF
`define FILD_W0_MID      3'h0
`define FILD_OP_INT      7'h01
`define FILD_OP_INTRZ    7'h03
`define FILD_OP_LOG10    7'h15
// source formats
`define FILD_FMT_L       3'h0
`define FILD_FMT_S       3'h1
`define FILD_FMT_P       3'h3
`define FILD_FMT_W       3'h4
`define FILD_FMT_B       3'h6
`define FILD_FMT_BAD     3'h7
// address modes
`define FILD_MODE_DN     3'h0
`define FILD_MODE_AN     3'h1
`define FILD_MODE_IND    3'h2
`define FILD_MODE_EXT    3'h7
`define FILD_EXT_IMM     3'h4
// operand classes
`define FILD_CL_NORM     2'h0
`define FILD_CL_ZERO     2'h1
`define FILD_CL_INF      2'h2
`define FILD_CL_NAN      2'h3
// exception byte bit positions
`define FILD_EX_BRANCH_UNORDERED_BIT     7
`define FILD_EX_SIGNALLING_NAN_BIT     6
`define FILD_EX_OPERAND_ERROR_BIT    5
`define FILD_EX_OVERFLOW_BIT     4
`define FILD_EX_UNDERFLOW_BIT     3
`define FILD_EX_DZ       2
`define FILD_EX_RESULT_INEXACT_BIT    1
`define FILD_EX_DECIMAL_INPUT_INEXACT_BIT    0
// first word field positions
`define FILD_W0_TOP_HI   15
`define FILD_W0_TOP_LO   12
`define FILD_W0_ID_HI    11
`define FILD_W0_ID_LO    9
`define FILD_W0_MID_HI   8
`define FILD_W0_MID_LO   6
`define FILD_EA_MODE_HI  5
`define FILD_EA_MODE_LO  3
`define FILD_EA_REG_HI   2
`define FILD_EA_REG_LO   0
// second word field positions
`define FILD_W1_ZERO_HI  15
`define FILD_W1_RM       14
`define FILD_W1_ZERO_LO  13
`define FILD_W1_SPEC_HI  12
`define FILD_W1_SPEC_LO  10
`define FILD_W1_DST_HI   9
`define FILD_W1_DST_LO   7
`define FILD_W1_OP_HI    6
`define FILD_W1_OP_LO    0
// register write field positions
`define FILD_CTRL_HI     7
`define FILD_CTRL_LO     0
`define FILD_QUOT_HI     23
`define FILD_QUOT_LO     16
`define FILD_ACCR_HI     7
`define FILD_ACCR_LO     0
`endif

// ===== hw/fild_top.v
// decoder and status unit for integer part and base-ten logarithm operations
`timescale 1ns/10ps
`default_nettype none
`include "fild_regs.vh"
module fild_top #(
  parameter [2:0] CP_ID = 3'h1
) (
  // clock and reset
  input  wire        core_clk_i,
  input  wire        resetn_i,
  // instruction and operand class, same clock
  input  wire        instr_valid_i,
  input  wire [15:0] instr_word0_i,
  input  wire [15:0] instr_word1_i,
  input  wire [1:0]  src_class_i,
  input  wire        src_sign_i,
  input  wire        src_signalling_nan_bit_i,
  input  wire        pk_inexact_i,
  input  wire        res_inexact_i,
  input  wire        res_sign_i,
  input  wire        res_zero_i,
  // register port
  input  wire [3:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  // decoded operation
  output reg         dec_valid_o,
  output reg         dec_illegal_o,
  output reg  [1:0]  op_sel_o,
  output reg         mem_src_o,
  output reg  [2:0]  fp_source_register_o,
  output reg  [2:0]  src_fmt_o,
  output reg  [2:0]  fp_dest_register_o,
  output reg  [2:0]  ea_mode_o,
  output reg  [2:0]  ea_reg_o,
  output reg  [1:0]  round_mode_o,
  output reg         special_o,
  output reg  [1:0]  spec_class_o,
  output reg         spec_sign_o
);

  //------------------------------------------------------------
  // decode
  //------------------------------------------------------------
  localparam [1:0] OP_INT   = 2'h0;
  localparam [1:0] OP_INTRZ = 2'h1;
  localparam [1:0] OP_LOG   = 2'h2;
  localparam [1:0] OP_NONE  = 2'h3;

  reg  [7:0]  ctrl_reg;
  reg  [3:0]  cc_reg;
  reg  [7:0]  quot_reg;
  reg  [7:0]  exc_reg;
  reg  [7:0]  accr_reg;

  wire        rm_bit   = instr_word1_i[`FILD_W1_RM];
  wire [2:0]  spec_fld = instr_word1_i[`FILD_W1_SPEC_HI:`FILD_W1_SPEC_LO];
  wire [2:0]  dst_fld  = instr_word1_i[`FILD_W1_DST_HI:`FILD_W1_DST_LO];
  wire [6:0]  op_fld   = instr_word1_i[`FILD_W1_OP_HI:`FILD_W1_OP_LO];
  wire [2:0]  mode_fld = instr_word0_i[`FILD_EA_MODE_HI:`FILD_EA_MODE_LO];
  wire [2:0]  reg_fld  = instr_word0_i[`FILD_EA_REG_HI:`FILD_EA_REG_LO];
  reg  [1:0]  op_next;
  reg         bad_ea;
  reg         ill_next;

  // operation field and addressing legality
  always @* begin
    case (op_fld)
      `FILD_OP_INT:   op_next = OP_INT;
      `FILD_OP_INTRZ: op_next = OP_INTRZ;
      `FILD_OP_LOG10: op_next = OP_LOG;
      default:        op_next = OP_NONE;
    endcase
    bad_ea = 1'b0;
    if (rm_bit) begin
      if (spec_fld == `FILD_FMT_BAD) begin
        bad_ea = 1'b1;
      end
      case (mode_fld)
        `FILD_MODE_DN: bad_ea = bad_ea | ~((spec_fld == `FILD_FMT_B) | (spec_fld == `FILD_FMT_W) |
                                           (spec_fld == `FILD_FMT_L) | (spec_fld == `FILD_FMT_S));
        `FILD_MODE_AN: bad_ea = 1'b1;
        `FILD_MODE_EXT: bad_ea = bad_ea | (reg_fld > `FILD_EXT_IMM);
        default: bad_ea = bad_ea;
      endcase
    end
    ill_next = (instr_word0_i[`FILD_W0_TOP_HI:`FILD_W0_TOP_LO] != `FILD_W0_TOP) |
               (instr_word0_i[`FILD_W0_ID_HI:`FILD_W0_ID_LO] != CP_ID) |
               (instr_word0_i[`FILD_W0_MID_HI:`FILD_W0_MID_LO] != `FILD_W0_MID) |
               instr_word1_i[`FILD_W1_ZERO_HI] | instr_word1_i[`FILD_W1_ZERO_LO] |
               (op_next == OP_NONE) | bad_ea;
  end

  //------------------------------------------------------------
  // special operand results and exception byte
  //------------------------------------------------------------
  reg         sp_next;
  reg  [1:0]  scl_next;
  reg         ssg_next;
  reg  [7:0]  exc_next;
  reg  [3:0]  cc_next;
  wire        is_nan  = (src_class_i == `FILD_CL_NAN);
  wire        is_zero = (src_class_i == `FILD_CL_ZERO);
  wire        is_inf  = (src_class_i == `FILD_CL_INF);
  // packed memory operand lets the conversion report decimal inexact
  wire        mem_fmt_p = rm_bit & (spec_fld == `FILD_FMT_P);

  always @* begin
    sp_next  = 1'b1;
    scl_next = src_class_i;
    ssg_next = src_sign_i;
    exc_next = 8'h00;
    exc_next[`FILD_EX_SIGNALLING_NAN_BIT]  = is_nan & src_signalling_nan_bit_i;
    exc_next[`FILD_EX_DECIMAL_INPUT_INEXACT_BIT] = (mem_fmt_p) & pk_inexact_i;
    if (is_nan) begin
      scl_next = `FILD_CL_NAN;
    end else if (op_next == OP_LOG) begin
      if (src_sign_i & ~is_zero) begin
        scl_next = `FILD_CL_NAN;
        exc_next[`FILD_EX_OPERAND_ERROR_BIT] = 1'b1;
      end else if (is_zero) begin
        scl_next = `FILD_CL_INF;
        ssg_next = 1'b1;
        exc_next[`FILD_EX_DZ] = 1'b1;
      end else if (!is_inf) begin
        sp_next = 1'b0;
      end
    end else if (!is_zero && !is_inf) begin
      sp_next = 1'b0;
    end
    // in range results take sign and zero from the arithmetic unit
    if (!sp_next) begin
      scl_next = res_zero_i ? `FILD_CL_ZERO : `FILD_CL_NORM;
      ssg_next = res_sign_i;
      exc_next[`FILD_EX_RESULT_INEXACT_BIT] = res_inexact_i;
    end
    // condition codes: negative, zero, infinity, nan
    cc_next = {ssg_next, scl_next == `FILD_CL_ZERO, scl_next == `FILD_CL_INF,
               scl_next == `FILD_CL_NAN};
  end

  wire accept    = instr_valid_i & ~ill_next;

  //------------------------------------------------------------
  // decoded outputs
  //------------------------------------------------------------
  // latch decode one cycle after the instruction is offered
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      dec_valid_o          <= 1'b0;
      dec_illegal_o        <= 1'b0;
      op_sel_o             <= OP_NONE;
      mem_src_o            <= 1'b0;
      fp_source_register_o <= 3'h0;
      src_fmt_o            <= 3'h0;
      fp_dest_register_o   <= 3'h0;
      ea_mode_o            <= 3'h0;
      ea_reg_o             <= 3'h0;
      round_mode_o         <= 2'h0;
      special_o            <= 1'b0;
      spec_class_o         <= 2'h0;
      spec_sign_o          <= 1'b0;
    end else begin
      dec_valid_o   <= accept;
      dec_illegal_o <= instr_valid_i & ill_next;
      if (instr_valid_i) begin
        op_sel_o             <= op_next;
        mem_src_o            <= rm_bit;
        fp_source_register_o <= rm_bit ? 3'h0 : spec_fld;
        src_fmt_o            <= rm_bit ? spec_fld : 3'h0;
        fp_dest_register_o   <= dst_fld;
        ea_mode_o            <= rm_bit ? mode_fld : 3'h0;
        ea_reg_o             <= rm_bit ? reg_fld : 3'h0;
        round_mode_o         <= (op_next == OP_INTRZ) ? `FILD_RM_ZERO
                              : ctrl_reg[`FILD_RMODE_HI:`FILD_RMODE_LO];
        special_o            <= sp_next;
        spec_class_o         <= scl_next;
        spec_sign_o          <= ssg_next;
      end
    end
  end

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  wire wr_ctrl = reg_wr_i & (reg_addr_i == `FILD_ADDR_CTRL);
  wire wr_stat = reg_wr_i & (reg_addr_i == `FILD_ADDR_STAT);

  // control, status and accrued state; a clear in the same cycle as a completed operation drops old accrued bits, then ORs in new exceptions
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ctrl_reg <= `FILD_CTRL_RST;
      cc_reg   <= 4'h0;
      quot_reg <= 8'h00;
      exc_reg  <= 8'h00;
      accr_reg <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata_i[`FILD_CTRL_HI:`FILD_CTRL_LO];
      end
      if (wr_stat) begin
        quot_reg <= reg_wdata_i[`FILD_QUOT_HI:`FILD_QUOT_LO];
      end
      if (accept) begin
        cc_reg   <= cc_next;
        exc_reg  <= exc_next;
        accr_reg <= (accr_reg & ~(wr_stat ? reg_wdata_i[`FILD_ACCR_HI:`FILD_ACCR_LO] : 8'h00)) | exc_next;
      end else if (wr_stat) begin
        accr_reg <= accr_reg & ~reg_wdata_i[`FILD_ACCR_HI:`FILD_ACCR_LO];
      end
    end
  end

  // read data stands the cycle after the strobe
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `FILD_ADDR_CTRL: reg_rdata_o <= {24'h000000, ctrl_reg};
        `FILD_ADDR_STAT: reg_rdata_o <= {4'h0, cc_reg, quot_reg, exc_reg, accr_reg};
        `FILD_ADDR_DEC:  reg_rdata_o <= {16'h0000, dec_illegal_o, dec_valid_o, op_sel_o, mem_src_o,
                                         src_fmt_o, fp_dest_register_o, ea_mode_o, 2'h0};
        default:         reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

endmodule // fild_top
`default_nettype wire

// ===== bench/fild_top_asserts.sv
// port assertions for the integer part and base-ten logarithm decoder
`timescale 1ns/10ps
`default_nettype none
module fild_top_asserts #(
  parameter [2:0] CP_ID = 3'h1
) (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  // instruction side
  input wire logic        instr_valid_i,
  input wire logic [15:0] instr_word0_i,
  input wire logic [15:0] instr_word1_i,
  input wire logic [1:0]  src_class_i,
  input wire logic        src_sign_i,
  // decoded side
  input wire logic        dec_illegal_o,
  input wire logic [1:0]  op_sel_o,
  input wire logic        mem_src_o,
  input wire logic [2:0]  fp_source_register_o,
  input wire logic [2:0]  src_fmt_o,
  input wire logic [2:0]  fp_dest_register_o,
  input wire logic [2:0]  ea_mode_o,
  input wire logic [1:0]  round_mode_o,
  input wire logic        special_o,
  input wire logic [1:0]  spec_class_o,
  input wire logic        spec_sign_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // instruction word framing, unit selection and address register direct
  AST_TOP: assert property (instr_valid_i && (instr_word0_i[15:12] != 4'hF || instr_word0_i[8:6] != 3'h0)
    |=> dec_illegal_o) else $error("bad first word accepted");
  AST_ID: assert property (instr_valid_i && instr_word0_i[11:9] != CP_ID |=> dec_illegal_o)
    else $error("foreign unit id accepted");
  AST_ADDRD: assert property (instr_valid_i && instr_word1_i[14] && instr_word0_i[5:3] == 3'h1
    |=> dec_illegal_o) else $error("address direct accepted");
  // operation effects
  AST_TRUNC: assert property (instr_valid_i && instr_word1_i[6:0] == 7'h03
    |=> dec_illegal_o || (op_sel_o == 2'h1 && round_mode_o == 2'h1)) else $error("truncation mode wrong");
  AST_LOGZ: assert property (instr_valid_i && instr_word1_i[6:0] == 7'h15 && src_class_i == 2'h1
    |=> dec_illegal_o || (special_o && spec_class_o == 2'h2 && spec_sign_o)) else $error("log of zero wrong");
  AST_LOGNEG: assert property (instr_valid_i && instr_word1_i[6:0] == 7'h15 && src_sign_i && !src_class_i[0]
    |=> dec_illegal_o || (special_o && spec_class_o == 2'h3)) else $error("log of negative wrong");
  // operand fields
  AST_REGF: assert property (instr_valid_i && !instr_word1_i[14] |=> dec_illegal_o || (!mem_src_o
    && ea_mode_o == 3'h0 && fp_source_register_o == $past(instr_word1_i[12:10])
    && fp_dest_register_o == $past(instr_word1_i[9:7]))) else $error("register form fields wrong");
  AST_FMT: assert property (instr_valid_i && instr_word1_i[14] |=> dec_illegal_o || (mem_src_o
    && src_fmt_o == $past(instr_word1_i[12:10]) && ea_mode_o == $past(instr_word0_i[5:3])))
    else $error("memory form fields wrong");
endmodule // fild_top_asserts
`default_nettype wire

// ===== bench/fild_host.sv
// host processor model that issues decoder instructions
`timescale 1ns/10ps
`default_nettype none
module fild_host #(
  parameter [2:0] CP_ID = 3'h1
) (
  // clock
  input  wire logic        clk_i,
  // instruction and operand info
  output logic             valid_o,
  output logic [15:0]      w0_o,
  output logic [15:0]      w1_o,
  output logic [1:0]       cls_o,
  output logic             sgn_o,
  output logic             pk_o,
  output logic             rinx_o
);
  logic [15:0] lw0;
  logic [15:0] lw1;
  // quiet bus at time zero
  initial {valid_o, w0_o, w1_o, cls_o, sgn_o, pk_o, rinx_o} = '0;
  // one instruction for one cycle; released words are scrambled
  task automatic issue(input logic m, input logic [5:0] ea, input logic [2:0] s, d, input logic [6:0] op,
                       input logic [15:0] xr, input logic [1:0] c, input logic sg, pk, rx);
    lw0 = {4'hF, CP_ID, 3'h0, m ? ea : 6'h00} ^ xr;
    lw1 = {1'b0, m, 1'b0, s, d, op};
    @(posedge clk_i);
    {valid_o, w0_o, w1_o, cls_o, sgn_o, pk_o, rinx_o} <= {1'b1, lw0, lw1, c, sg, pk, rx};
    @(posedge clk_i);
    {valid_o, w0_o, w1_o} <= {1'b0, ~lw0, ~lw1};
  endtask
endmodule // fild_host
`default_nettype wire

// ===== bench/fild_top_tb.sv
// self-checking bench for the integer part and base-ten logarithm decoder
`timescale 1ns/10ps
`default_nettype none
module fild_top_tb;
  localparam [2:0] CP_ID = 3'h1;
  logic        core_clk_i = 0, resetn_i = 0, rwr = 0, rrd = 0;
  logic [3:0]  ra = 0;
  logic [31:0] rw = 0, rv, r;
  logic [7:0]  ex = 0, acc = 0;
  logic [3:0]  cc = 0;
  logic [1:0]  cm = 2'h3;
  logic [6:0]  op;
  int          miscompares = 0, n_tests = 0;
  wire         vl, sg, pk, rx, dv, di, ms, sp, ss;
  wire [15:0]  w0, w1;
  wire [1:0]   cl, os, rm, sc;
  wire [2:0]   fs, sf, fd, em, er;
  wire [31:0]  rd_o;
  fild_host #(.CP_ID(CP_ID)) host (.clk_i(core_clk_i), .valid_o(vl), .w0_o(w0), .w1_o(w1), .cls_o(cl),
    .sgn_o(sg), .pk_o(pk), .rinx_o(rx));
  fild_top #(.CP_ID(CP_ID)) DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .instr_valid_i(vl),
    .instr_word0_i(w0), .instr_word1_i(w1), .src_class_i(cl), .src_sign_i(sg), .src_signalling_nan_bit_i(rx),
    .pk_inexact_i(pk), .res_inexact_i(rx), .res_sign_i(sg), .res_zero_i(pk), .reg_addr_i(ra),
    .reg_wdata_i(rw), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rd_o), .dec_valid_o(dv),
    .dec_illegal_o(di), .op_sel_o(os), .mem_src_o(ms), .fp_source_register_o(fs), .src_fmt_o(sf),
    .fp_dest_register_o(fd), .ea_mode_o(em), .ea_reg_o(er), .round_mode_o(rm), .special_o(sp),
    .spec_class_o(sc), .spec_sign_o(ss));
  initial forever #50 core_clk_i = ~core_clk_i;
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    {rwr, ra, rw} <= {1'b1, a, d};
    @(posedge core_clk_i);
    rwr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk_i);
    {rrd, ra} <= {1'b1, a};
    @(posedge core_clk_i);
    rrd <= 1'b0;
    #1 rv = rd_o;
  endtask
  function automatic logic ok_of(input logic [15:0] a, b);
    ok_of = a[15:6] == {4'hF, CP_ID, 3'h0} && !b[15] && !b[13] && b[6:0] inside {7'h01, 7'h03, 7'h15};
    if (b[14]) ok_of &= b[12:10] != 3'h7 && a[5:3] != 3'h1 && !(a[5:3] == 3'h7 && a[2:0] > 3'h4)
      && !(a[5:3] == 3'h0 && b[12:10] inside {3'h2, 3'h3, 3'h5});
  endfunction
  function automatic logic [7:0] exc_of(input logic [1:0] c, input logic s, p, x);
    exc_of = {7'h00, p};
    if (c == 2'h3) exc_of[6] = x;
    else if (op == 7'h15 && s && c != 2'h1) exc_of[5] = 1'b1;
    else if (op == 7'h15 && c == 2'h1) exc_of[2] = 1'b1;
    else if (c == 2'h0) exc_of[1] = x;
  endfunction
  // expected condition codes: negative, zero, infinity, nan
  function automatic logic [3:0] cc_of(input logic [1:0] c, input logic s, z);
    if (c == 2'h3 || (op == 7'h15 && s && c != 2'h1)) cc_of = {s, 3'h1};
    else if (op == 7'h15 && c == 2'h1) cc_of = 4'hA;
    else if (c == 2'h1) cc_of = {s, 3'h4};
    else if (c == 2'h2) cc_of = {s, 3'h2};
    else cc_of = {s, z, 2'h0};
  endfunction
  // one instruction with its decode and status checks
  task automatic step(input logic m, input logic [5:0] ea, input logic [2:0] s, d, input logic [15:0] xr,
                      input logic [1:0] c, input logic sn, p, x);
    logic ok;
    wr(4'h0, {26'h0, cm, 4'h0});
    host.issue(m, ea, s, d, op, xr, c, sn, p, x);
    // decode pulses are launched on the edge that ends the issue
    #1;
    ok = ok_of(host.lw0, host.lw1);
    chk("valid", ok, dv);
    chk("illegal", !ok, di);
    if (ok) begin
      chk("op", op == 7'h01 ? 2'h0 : op == 7'h03 ? 2'h1 : 2'h2, os);
      chk("round", op == 7'h03 ? 2'h1 : cm, rm);
      chk("dest", d, fd);
      chk("fields", m ? {1'b1, s, ea} : {1'b0, s, 6'h00}, {ms, m ? sf : fs, em, er});
      ex = exc_of(c, sn, m && s == 3'h3 && p, x);
      cc = cc_of(c, sn, p);
      acc |= ex;
    end
    rd(4'h4);
    chk("status", {4'h0, cc, 8'h5A, ex, acc}, rv);
  endtask
  initial begin
    void'($urandom(23));
    repeat (2) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rd(4'h0);
    chk("ctrl", 0, rv);
    rd(4'hC);
    chk("unmapped", 0, rv);
    wr(4'h4, 32'h005A_0000);
    op = 7'h15;
    step(1'b0, 6'h00, 3'h0, 3'h0, 16'h0, 2'h1, 1'b1, 1'b0, 1'b0);
    step(1'b1, 6'h3C, 3'h4, 3'h2, 16'h0, 2'h0, 1'b1, 1'b0, 1'b1);
    rd(4'h8);
    chk("decode", 32'h0000_2C5C, rv);
    op = 7'h03;
    step(1'b1, 6'h13, 3'h3, 3'h5, 16'h0, 2'h0, 1'b0, 1'b1, 1'b1);
    op = 7'h22;
    step(1'b0, 6'h00, 3'h1, 3'h1, 16'h0, 2'h0, 1'b0, 1'b0, 1'b0);
    repeat (80) begin
      r = $urandom;
      op = r[19:18] == 2'h0 ? 7'h01 : r[19:18] == 2'h1 ? 7'h03 : 7'h15;
      cm = r[21:20];
      step(r[0], r[6:1], r[9:7], r[12:10], r[24:22] == 3'h6 ? 16'h0200 : r[24:22] == 3'h7 ? 16'h0040 : 16'h0,
           r[14:13], r[15], r[16], r[17]);
      if (r[25] && r[26]) begin
        wr(4'h4, 32'h005A_00FF);
        acc = 0;
      end
    end
    wrap_up;
  end
  initial begin
    #500000;
    miscompares++;
    wrap_up;
  end
  task automatic wrap_up;
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
endmodule // fild_top_tb
bind fild_top fild_top_asserts #(.CP_ID(CP_ID)) u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
  .instr_valid_i(instr_valid_i), .instr_word0_i(instr_word0_i), .instr_word1_i(instr_word1_i),
  .src_class_i(src_class_i), .src_sign_i(src_sign_i), .dec_illegal_o(dec_illegal_o), .op_sel_o(op_sel_o),
  .mem_src_o(mem_src_o), .fp_source_register_o(fp_source_register_o), .src_fmt_o(src_fmt_o),
  .fp_dest_register_o(fp_dest_register_o), .ea_mode_o(ea_mode_o), .round_mode_o(round_mode_o),
  .special_o(special_o), .spec_class_o(spec_class_o), .spec_sign_o(spec_sign_o));
`default_nettype wire
